// [pscs_pkg.sv]
// Operation
// - backplane bus exchange only with local-base specialty modules, reads and writes
// - clock segment copies clock/calendar into reserved memory and refreshes special relays
// - program solved rung by rung from first rung until end coil
// - program solve also updates control relays and the output image
// - forces held in output image; program results overwrite forced outputs
// - after solve, only configured pid loops run, each at its own interval
// - whole output image, forces included, written to local and expansion outputs
// - specialty and remote outputs sent once per scan after local writes
// - diagnostics computes scan time and restarts watchdog; special relays refreshed in clock segment
// - watchdog limit default 200ms; overrun forces program mode, outputs off
// - scan overrun reported with error code 0E03
// - limit configurable; restart instruction restarts watchdog mid-scan
// - min, max, current scan time tracked; cleared on program-to-run
// - immediate input reads module directly without touching input image
// - immediate outputs drive physical points during program solve
// - inputs changed after input read are captured only next scan
// - inputs read in every mode; outputs updated only in run mode
package pscs_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned WDOG_LIMIT_MS   = 200;
    localparam int unsigned WDOG_LIMIT_CYC  = (CLK_HZ / 1000) * WDOG_LIMIT_MS;
    localparam logic [15:0] ERR_NONE        = 16'h0000;
    localparam logic [15:0] ERR_SCAN_OVERRUN = 16'h0e03;
    localparam int unsigned PID_SLOTS       = 16;
    localparam logic        MODE_PROGRAM    = 1'b0;
    localparam logic        MODE_RUN        = 1'b1;

    typedef enum logic [10:0] {
        PSCS_IDLE    = 11'h001,
        PSCS_IN_LOC  = 11'h002,
        PSCS_IN_SPEC = 11'h004,
        PSCS_PERIPH  = 11'h008,
        PSCS_BUS     = 11'h010,
        PSCS_CLOCK   = 11'h020,
        PSCS_SOLVE   = 11'h040,
        PSCS_PID     = 11'h080,
        PSCS_OUT_LOC = 11'h100,
        PSCS_OUT_SPC = 11'h200,
        PSCS_DIAG    = 11'h400
    } pscs_seg_t;
endpackage

// [pscs_watchdog.sv]
`timescale 1ns/1ps
`default_nettype none
module pscs_watchdog
    import pscs_pkg::*;
#(
    parameter int unsigned W = 32
) (
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire logic         restart_i,
    input  wire logic         enable_i,
    input  wire logic [W-1:0] limit_i,
    output logic              overrun_o
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         ovr_reg;
    logic         ovr_next;
    logic         hit;

    // at or above, so a limit lowered mid-scan still trips
    assign hit = enable_i && (cnt_reg >= limit_i);

    always_comb begin
        cnt_next = cnt_reg;
        ovr_next = 1'b0;
        if (restart_i || !enable_i) begin
            cnt_next = '0;
        end else if (hit) begin
            ovr_next = 1'b1;
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= '0;
            ovr_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ovr_reg <= ovr_next;
        end
    end

    assign overrun_o = ovr_reg;

    chk_wdog_pulse_one: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        overrun_o |=> !overrun_o) else $error("overrun longer than one cycle");
    chk_wdog_match_fire: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (enable_i && !restart_i && cnt_reg == limit_i) |=> overrun_o)
        else $error("limit match without overrun");
endmodule
`default_nettype wire

// [pscs_scan_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module pscs_scan_timer
    import pscs_pkg::*;
#(
    parameter int unsigned W = 32
) (
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire logic         clear_i,
    input  wire logic         scan_end_i,
    output logic [W-1:0]      cur_o,
    output logic [W-1:0]      min_o,
    output logic [W-1:0]      max_o
);
    logic [W-1:0] run_reg, run_next;
    logic [W-1:0] cur_reg, cur_next;
    logic [W-1:0] min_reg, min_next;
    logic [W-1:0] max_reg, max_next;
    logic [W-1:0] len;

    assign len = run_reg + 1'b1;

    always_comb begin
        run_next = run_reg + 1'b1;
        cur_next = cur_reg;
        min_next = min_reg;
        max_next = max_reg;
        if (clear_i) begin
            run_next = '0;
            cur_next = '0;
            min_next = '1;
            max_next = '0;
        end else if (scan_end_i) begin
            run_next = '0;
            cur_next = len;
            if (len < min_reg) min_next = len;
            if (len > max_reg) max_next = len;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_reg <= '0;
            cur_reg <= '0;
            min_reg <= '1;
            max_reg <= '0;
        end else begin
            run_reg <= run_next;
            cur_reg <= cur_next;
            min_reg <= min_next;
            max_reg <= max_next;
        end
    end

    assign cur_o = cur_reg;
    assign min_o = min_reg;
    assign max_o = max_reg;

    chk_scan_clear_all: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        clear_i |=> (cur_o == '0 && max_o == '0 && min_o == '1))
        else $error("scan stats not cleared");
    chk_scan_max_bound: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (scan_end_i && !clear_i) |=> (max_o >= cur_o && min_o <= cur_o))
        else $error("min max out of order");
endmodule
`default_nettype wire

// [pscs_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module pscs_sequencer
    import pscs_pkg::*;
#(
    parameter int unsigned NIN      = 16,
    parameter int unsigned NOUT     = 16,
    parameter int unsigned NLOOP    = 16,
    parameter int unsigned TW       = 32,
    parameter int unsigned WDOG_CYC = WDOG_LIMIT_CYC
) (
    input  wire logic             CLOCK_I,
    input  wire logic             ARST_N_I,
    input  wire logic             RUN_REQ_I,
    input  wire logic [NIN-1:0]   LOCAL_IN_I,
    input  wire logic [NIN-1:0]   REMOTE_IN_I,
    input  wire logic [NOUT-1:0]  FORCE_MASK_I,
    input  wire logic [NOUT-1:0]  FORCE_VAL_I,
    input  wire logic             BUS_REQ_I,
    input  wire logic             BUS_LOCAL_I,
    input  wire logic             BUS_WRITE_I,
    input  wire logic [15:0]      BUS_WDATA_I,
    output logic                  BUS_ACK_O,
    output logic [15:0]           BUS_RDATA_O,
    input  wire logic [15:0]      RTC_I,
    output logic [15:0]           RTC_MEM_O,
    output logic [7:0]            SPECIAL_RELAY_O,
    input  wire logic             INSTR_VALID_I,
    input  wire logic             INSTR_END_I,
    input  wire logic             INSTR_IMM_IN_I,
    input  wire logic             INSTR_IMM_OUT_I,
    input  wire logic             INSTR_WRITE_OUT_I,
    input  wire logic             INSTR_WRITE_CTL_I,
    input  wire logic             WATCHDOG_RESTART_INSTRUCTION_I,
    input  wire logic [7:0]       INSTR_ADDR_I,
    input  wire logic             INSTR_BIT_I,
    output logic                  INSTR_READY_O,
    output logic [7:0]            RUNG_PC_O,
    output logic                  INSTR_BIT_O,
    output logic [255:0]          CTL_RELAY_O,
    input  wire logic [NLOOP-1:0] LOOP_CFG_I,
    input  wire logic [NLOOP-1:0] LOOP_DUE_I,
    output logic [NLOOP-1:0]      LOOP_RUN_O,
    output logic [NOUT-1:0]       LOCAL_OUT_O,
    output logic [NOUT-1:0]       REMOTE_OUT_O,
    output logic                  REMOTE_OUT_STB_O,
    input  wire logic [TW-1:0]    WDOG_LIMIT_I,
    input  wire logic             WDOG_LIMIT_SET_I,
    output logic                  RUN_MODE_O,
    output logic [15:0]           ERROR_CODE_O,
    output logic [TW-1:0]         SCAN_CUR_O,
    output logic [TW-1:0]         SCAN_MIN_O,
    output logic [TW-1:0]         SCAN_MAX_O
);
    pscs_seg_t         seg_reg, seg_next;
    logic [NIN-1:0]    img_in_reg, img_in_next;
    logic [NIN-1:0]    img_rem_reg, img_rem_next;
    logic [NOUT-1:0]   img_out_reg, img_out_next;
    logic [NOUT-1:0]   lout_reg, lout_next;
    logic [NOUT-1:0]   rout_reg, rout_next;
    logic              rstb_reg, rstb_next;
    logic              mode_reg, mode_next;
    logic [15:0]       err_reg, err_next;
    logic [15:0]       rtc_reg, rtc_next;
    logic [7:0]        sr_reg, sr_next;
    logic [15:0]       bus_reg, bus_next;
    logic [15:0]       bus_rd_reg, bus_rd_next;
    logic              ack_reg, ack_next;
    logic [7:0]        pc_reg, pc_next;
    logic              ibit_reg, ibit_next;
    logic [255:0]      ctl_reg, ctl_next;
    logic [NLOOP-1:0]  loop_reg, loop_next;
    logic [TW-1:0]     lim_reg, lim_next;
    logic              overrun;
    logic              wd_restart;
    logic              clr_stats;
    logic              scan_end;

    assign wd_restart = (seg_reg == PSCS_DIAG) || (seg_reg == PSCS_IDLE)
                      || (seg_reg == PSCS_SOLVE && INSTR_VALID_I
                          && WATCHDOG_RESTART_INSTRUCTION_I);
    // decoded from registered state, not from mode_next, to keep the next-state logic loop free
    assign clr_stats = (mode_reg == MODE_PROGRAM) && (seg_reg == PSCS_PERIPH)
                     && RUN_REQ_I && !overrun;
    assign scan_end  = (seg_reg == PSCS_DIAG);

    function automatic logic bit_of(input logic [NIN-1:0] v, input logic [7:0] a);
        bit_of = (a < NIN) ? v[a[$clog2(NIN)-1:0]] : 1'b0;
    endfunction

    always_comb begin
        seg_next     = seg_reg;
        img_in_next  = img_in_reg;
        img_rem_next = img_rem_reg;
        img_out_next = img_out_reg;
        lout_next    = lout_reg;
        rout_next    = rout_reg;
        rstb_next    = 1'b0;
        mode_next    = mode_reg;
        err_next     = err_reg;
        rtc_next     = rtc_reg;
        sr_next      = sr_reg;
        bus_next     = bus_reg;
        bus_rd_next  = bus_rd_reg;
        ack_next     = 1'b0;
        pc_next      = pc_reg;
        ibit_next    = ibit_reg;
        ctl_next     = ctl_reg;
        loop_next    = '0;
        lim_next     = WDOG_LIMIT_SET_I ? WDOG_LIMIT_I : lim_reg;
        unique case (seg_reg)
            PSCS_IDLE: seg_next = PSCS_IN_LOC;
            PSCS_IN_LOC: begin
                img_in_next = LOCAL_IN_I;
                seg_next    = PSCS_IN_SPEC;
            end
            PSCS_IN_SPEC: begin
                img_rem_next = REMOTE_IN_I;
                seg_next     = PSCS_PERIPH;
            end
            PSCS_PERIPH: begin
                img_out_next = (img_out_reg & ~FORCE_MASK_I)
                             | (FORCE_VAL_I & FORCE_MASK_I);
                mode_next    = RUN_REQ_I ? MODE_RUN : MODE_PROGRAM;
                seg_next     = PSCS_BUS;
            end
            PSCS_BUS: begin
                if (BUS_REQ_I && BUS_LOCAL_I) begin
                    ack_next = 1'b1;
                    if (BUS_WRITE_I) bus_next = BUS_WDATA_I;
                    else bus_rd_next = bus_reg;
                end
                seg_next = PSCS_CLOCK;
            end
            PSCS_CLOCK: begin
                rtc_next    = RTC_I;
                sr_next     = {6'h00, (err_reg != ERR_NONE), mode_reg};
                pc_next     = 8'h00;
                seg_next    = PSCS_SOLVE;
            end
            PSCS_SOLVE: begin
                if (mode_reg == MODE_PROGRAM) begin
                    seg_next = PSCS_PID;
                end else if (INSTR_VALID_I) begin
                    pc_next = pc_reg + 8'h01;
                    if (INSTR_IMM_IN_I) ibit_next = bit_of(LOCAL_IN_I, INSTR_ADDR_I);
                    else ibit_next = bit_of(img_in_reg, INSTR_ADDR_I)
                                   | bit_of(img_rem_reg, INSTR_ADDR_I - 8'(NIN));
                    if (INSTR_WRITE_OUT_I && INSTR_ADDR_I < NOUT) begin
                        img_out_next[INSTR_ADDR_I[$clog2(NOUT)-1:0]] = INSTR_BIT_I;
                        if (INSTR_IMM_OUT_I)
                            lout_next[INSTR_ADDR_I[$clog2(NOUT)-1:0]] = INSTR_BIT_I;
                    end
                    if (INSTR_WRITE_CTL_I) ctl_next[INSTR_ADDR_I] = INSTR_BIT_I;
                    if (INSTR_END_I) seg_next = PSCS_PID;
                end
            end
            PSCS_PID: begin
                if (mode_reg == MODE_RUN) loop_next = LOOP_CFG_I & LOOP_DUE_I;
                seg_next = PSCS_OUT_LOC;
            end
            PSCS_OUT_LOC: begin
                lout_next = (mode_reg == MODE_RUN) ? img_out_reg : '0;
                seg_next  = PSCS_OUT_SPC;
            end
            PSCS_OUT_SPC: begin
                rout_next = (mode_reg == MODE_RUN) ? img_out_reg : '0;
                rstb_next = 1'b1;
                seg_next  = PSCS_DIAG;
            end
            PSCS_DIAG: seg_next = PSCS_IN_LOC;
            default: seg_next = PSCS_IDLE;
        endcase
        if (overrun) begin
            mode_next = MODE_PROGRAM;
            err_next  = ERR_SCAN_OVERRUN;
            lout_next = '0;
            rout_next = '0;
            seg_next  = PSCS_DIAG;
        end else if (clr_stats) begin
            err_next = ERR_NONE;
        end
        if (mode_next == MODE_PROGRAM && !overrun && seg_reg != PSCS_OUT_LOC) begin
            lout_next = '0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            seg_reg     <= PSCS_IDLE;
            img_in_reg  <= '0;
            img_rem_reg <= '0;
            img_out_reg <= '0;
            lout_reg    <= '0;
            rout_reg    <= '0;
            rstb_reg    <= 1'b0;
            mode_reg    <= MODE_PROGRAM;
            err_reg     <= ERR_NONE;
            rtc_reg     <= '0;
            sr_reg      <= '0;
            bus_reg     <= '0;
            bus_rd_reg  <= '0;
            ack_reg     <= 1'b0;
            pc_reg      <= '0;
            ibit_reg    <= 1'b0;
            ctl_reg     <= '0;
            loop_reg    <= '0;
            lim_reg     <= TW'(WDOG_CYC);
        end else begin
            seg_reg     <= seg_next;
            img_in_reg  <= img_in_next;
            img_rem_reg <= img_rem_next;
            img_out_reg <= img_out_next;
            lout_reg    <= lout_next;
            rout_reg    <= rout_next;
            rstb_reg    <= rstb_next;
            mode_reg    <= mode_next;
            err_reg     <= err_next;
            rtc_reg     <= rtc_next;
            sr_reg      <= sr_next;
            bus_reg     <= bus_next;
            bus_rd_reg  <= bus_rd_next;
            ack_reg     <= ack_next;
            pc_reg      <= pc_next;
            ibit_reg    <= ibit_next;
            ctl_reg     <= ctl_next;
            loop_reg    <= loop_next;
            lim_reg     <= lim_next;
        end
    end

    // watchdog only armed in run mode; program mode scans may stall on service
    pscs_watchdog #(.W(TW)) u_wdog (
        .clk_i     (CLOCK_I),
        .arst_n_i  (ARST_N_I),
        .restart_i (wd_restart),
        .enable_i  (mode_reg == MODE_RUN),
        .limit_i   (lim_reg),
        .overrun_o (overrun)
    );

    pscs_scan_timer #(.W(TW)) u_timer (
        .clk_i      (CLOCK_I),
        .arst_n_i   (ARST_N_I),
        .clear_i    (clr_stats),
        .scan_end_i (scan_end),
        .cur_o      (SCAN_CUR_O),
        .min_o      (SCAN_MIN_O),
        .max_o      (SCAN_MAX_O)
    );

    assign BUS_ACK_O        = ack_reg;
    assign BUS_RDATA_O      = bus_rd_reg;
    assign RTC_MEM_O        = rtc_reg;
    assign SPECIAL_RELAY_O  = sr_reg;
    assign INSTR_READY_O    = (seg_reg == PSCS_SOLVE) && (mode_reg == MODE_RUN);
    assign RUNG_PC_O        = pc_reg;
    assign INSTR_BIT_O      = ibit_reg;
    assign CTL_RELAY_O      = ctl_reg;
    assign LOOP_RUN_O       = loop_reg;
    assign LOCAL_OUT_O      = lout_reg;
    assign REMOTE_OUT_O     = rout_reg;
    assign REMOTE_OUT_STB_O = rstb_reg;
    assign RUN_MODE_O       = mode_reg;
    assign ERROR_CODE_O     = err_reg;

    chk_seg_order_fix: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        (seg_reg == PSCS_IN_LOC && !overrun) |=> seg_reg == PSCS_IN_SPEC ##1
        seg_reg == PSCS_PERIPH) else $error("segment order broken");
    chk_prog_outs_off: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        (mode_reg == MODE_PROGRAM && $past(mode_reg) == MODE_PROGRAM) |-> LOCAL_OUT_O == '0)
        else $error("outputs on in program mode");
    chk_overrun_react: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        overrun |=> (!RUN_MODE_O && ERROR_CODE_O == ERR_SCAN_OVERRUN && LOCAL_OUT_O == '0))
        else $error("overrun not handled");
    chk_input_capture: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        seg_reg == PSCS_IN_LOC |=> img_in_reg == $past(LOCAL_IN_I))
        else $error("input image not captured");
    chk_imm_in_image: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        seg_reg == PSCS_SOLVE |=> $stable(img_in_reg))
        else $error("input image changed in solve");
    chk_bus_local_only: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        BUS_ACK_O |-> $past(seg_reg) == PSCS_BUS && $past(BUS_LOCAL_I))
        else $error("bus ack outside local exchange");
    chk_remote_once: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        REMOTE_OUT_STB_O |-> $past(seg_reg) == PSCS_OUT_SPC)
        else $error("remote strobe outside its segment");
    chk_pid_gate: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        LOOP_RUN_O != '0 |-> (LOOP_RUN_O & ~$past(LOOP_CFG_I)) == '0)
        else $error("unconfigured loop run");
    chk_rtc_copy: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        seg_reg == PSCS_CLOCK |=> RTC_MEM_O == $past(RTC_I))
        else $error("clock not copied");
endmodule
`default_nettype wire

// [pscs_remote_master.sv]
`timescale 1ns/1ps
`default_nettype none
module pscs_remote_master #(
    parameter int unsigned NOUT    = 16,
    parameter int unsigned SEQ_CYC = 7
) (
    input  wire logic            clk_i,
    input  wire logic            arst_n_i,
    input  wire logic [NOUT-1:0] cpu_out_i,
    input  wire logic            cpu_out_stb_i,
    output logic      [NOUT-1:0] slave_out_o
);
    logic [NOUT-1:0] pending;
    int              tick;

    // cpu data waits for our own link sequence, not for the scan
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pending     <= '0;
            slave_out_o <= '0;
            tick        <= 0;
        end else begin
            if (cpu_out_stb_i) begin
                pending <= cpu_out_i;
            end
            tick <= (tick == SEQ_CYC - 1) ? 0 : tick + 1;
            if (tick == SEQ_CYC - 1) begin
                slave_out_o <= pending;
            end
        end
    end
endmodule
`default_nettype wire

// [plc_scan_cycle_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module plc_scan_cycle_sequencer_tb;
    import pscs_pkg::*;
    localparam int unsigned WD    = 200;
    localparam logic [5:0]  F_END = 6'h20;
    localparam logic [5:0]  F_IIN = 6'h10;
    localparam logic [5:0]  F_IO  = 6'h0c;
    localparam logic [5:0]  F_CTL = 6'h02;
    localparam logic [5:0]  F_RST = 6'h01;
    logic         clk = 1'b0;
    logic         arst_n, run_req, bus_req, bus_local, bus_write, valid, ibit, wd_set;
    logic [15:0]  local_in, remote_in, force_mask, force_val, bus_wdata, rtc;
    logic [15:0]  loop_cfg, loop_due, bus_rdata, rtc_mem, loop_run, lout, rout, err, slave;
    logic [5:0]   flags;
    logic [7:0]   iaddr, sp_relay, rung_pc;
    logic [31:0]  wd_limit, s_cur, s_min, s_max, c0;
    logic         bus_ack, ready, ibit_o, rstb, run_mode;
    logic [255:0] ctl;
    int           num_errors = 0;
    int           checks_done = 0;
    int           acks = 0;
    int           a0, n;
    logic [15:0]  loop_seen = '0;

    always #50 clk = ~clk;

    pscs_sequencer #(.WDOG_CYC(WD)) pscs_sequencer_i (
        .CLOCK_I(clk), .ARST_N_I(arst_n), .RUN_REQ_I(run_req), .LOCAL_IN_I(local_in),
        .REMOTE_IN_I(remote_in), .FORCE_MASK_I(force_mask), .FORCE_VAL_I(force_val),
        .BUS_REQ_I(bus_req), .BUS_LOCAL_I(bus_local), .BUS_WRITE_I(bus_write),
        .BUS_WDATA_I(bus_wdata), .BUS_ACK_O(bus_ack), .BUS_RDATA_O(bus_rdata),
        .RTC_I(rtc), .RTC_MEM_O(rtc_mem), .SPECIAL_RELAY_O(sp_relay),
        .INSTR_VALID_I(valid), .INSTR_END_I(flags[5]), .INSTR_IMM_IN_I(flags[4]),
        .INSTR_IMM_OUT_I(flags[3]), .INSTR_WRITE_OUT_I(flags[2]),
        .INSTR_WRITE_CTL_I(flags[1]), .WATCHDOG_RESTART_INSTRUCTION_I(flags[0]),
        .INSTR_ADDR_I(iaddr), .INSTR_BIT_I(ibit), .INSTR_READY_O(ready),
        .RUNG_PC_O(rung_pc), .INSTR_BIT_O(ibit_o), .CTL_RELAY_O(ctl),
        .LOOP_CFG_I(loop_cfg), .LOOP_DUE_I(loop_due), .LOOP_RUN_O(loop_run),
        .LOCAL_OUT_O(lout), .REMOTE_OUT_O(rout), .REMOTE_OUT_STB_O(rstb),
        .WDOG_LIMIT_I(wd_limit), .WDOG_LIMIT_SET_I(wd_set), .RUN_MODE_O(run_mode),
        .ERROR_CODE_O(err), .SCAN_CUR_O(s_cur), .SCAN_MIN_O(s_min), .SCAN_MAX_O(s_max)
    );

    pscs_remote_master #(.NOUT(16), .SEQ_CYC(7)) pscs_remote_master_i (
        .clk_i(clk), .arst_n_i(arst_n), .cpu_out_i(rout), .cpu_out_stb_i(rstb),
        .slave_out_o(slave)
    );

    always @(negedge clk) begin
        acks      <= acks + int'(bus_ack);
        loop_seen <= loop_seen | loop_run;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // which: 0 waits for solve, 1 for the remote strobe
    task automatic wait_for(input int which, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            if ((which == 0 ? ready : rstb) === 1'b1) begin
                return;
            end
        end
        num_errors++;
        $display("CHECK FAILED at %0t: wait %0d timed out", $time, which);
        end_of_test();
    endtask

    task automatic ex(input logic [5:0] f, input logic [7:0] a, input logic b);
        @(posedge clk);
        valid <= 1'b1;
        flags <= f;
        iaddr <= a;
        ibit  <= b;
        @(posedge clk);
        valid <= 1'b0;
        @(negedge clk);
    endtask

    task automatic finish_scan();
        ex(F_END, 8'h00, 1'b0);
        wait_for(1, 40);
    endtask

    task automatic t_program_mode();
        @(posedge clk);
        force_mask <= 16'hffff;
        force_val  <= 16'hffff;
        rtc        <= 16'h1234;
        n = 0;
        repeat (60) begin
            @(negedge clk);
            n += int'(ready === 1'b1);
        end
        cmp(lout, 16'h0000, "outputs off in program mode");
        cmp(n, 0, "no solve in program mode");
        cmp(rtc_mem, 16'h1234, "clock copied in program mode");
        cmp(acks, 0, "no ack for foreign base");
        @(posedge clk);
        force_val <= 16'h0000;
        repeat (30) @(posedge clk);
        $display("program mode test done");
    endtask

    task automatic t_run_force();
        @(posedge clk);
        rtc        <= 16'h5a3c;
        bus_local  <= 1'b1;
        loop_cfg   <= 16'h0005;
        loop_due   <= 16'h0007;
        force_mask <= 16'h00ff;
        force_val  <= 16'h00f0;
        run_req    <= 1'b1;
        wait_for(0, 60);
        ex(F_IO & 6'h04, 8'h04, 1'b0);
        ex(F_IO & 6'h04, 8'h08, 1'b1);
        ex(F_IO & 6'h04, 8'h00, 1'b1);
        ex(F_CTL, 8'h05, 1'b1);
        cmp(ctl[5], 1'b1, "control relay written");
        finish_scan();
        cmp(lout, 16'h01e1, "forces and results written");
        cmp(rout, 16'h01e1, "remote image after local");
        cmp(loop_seen, 16'h0005, "only configured due loops");
        cmp(rtc_mem, 16'h5a3c, "clock copied");
        cmp(sp_relay[0], 1'b1, "run relay");
        repeat (10) @(negedge clk);
        cmp(slave, 16'h01e1, "remote master applied");
        @(posedge clk);
        force_mask <= 16'h0000;
        $display("run and force test done");
    endtask

    task automatic t_immediate();
        a0 = acks;
        wait_for(0, 40);
        @(posedge clk);
        local_in  <= 16'h0008;
        bus_write <= 1'b0;
        ex(6'h00, 8'h03, 1'b0);
        cmp(ibit_o, 1'b0, "regular read uses image");
        ex(F_IIN, 8'h03, 1'b0);
        cmp(ibit_o, 1'b1, "immediate read live");
        ex(6'h00, 8'h03, 1'b0);
        cmp(ibit_o, 1'b0, "image untouched");
        ex(F_IO, 8'h09, 1'b1);
        cmp(lout[9], 1'b1, "immediate output in solve");
        finish_scan();
        wait_for(0, 40);
        cmp(acks - a0, 1, "one bus exchange per scan");
        cmp(bus_rdata, 16'h0c3a, "bus read returns written word");
        ex(6'h00, 8'h03, 1'b0);
        cmp(ibit_o, 1'b1, "late input seen next scan");
        ex(6'h00, 8'h10, 1'b0);
        cmp(ibit_o, 1'b1, "remote image read");
        finish_scan();
        $display("immediate test done");
    endtask

    task automatic t_scan_time();
        @(posedge clk);
        bus_local <= 1'b0;
        wait_for(0, 40);
        finish_scan();
        a0 = acks;
        wait_for(0, 40);
        c0 = s_cur;
        repeat (10) ex(6'h00, 8'h00, 1'b0);
        cmp(rung_pc, 8'h0a, "rung count from first rung");
        finish_scan();
        cmp(acks - a0, 0, "foreign base refused");
        wait_for(0, 40);
        cmp(s_cur - c0, 20, "scan time measured");
        cmp((s_min <= s_cur) && (s_cur <= s_max), 1'b1, "min cur max order");
        finish_scan();
        $display("scan time test done");
    endtask

    task automatic t_watchdog();
        wait_for(0, 40);
        repeat (8) begin
            ex(F_RST, 8'h00, 1'b0);
            repeat (46) @(posedge clk);
        end
        cmp(run_mode, 1'b1, "restart keeps run");
        ex(F_RST, 8'h00, 1'b0);
        n = 0;
        while (run_mode === 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        cmp(n >= 195 && n <= 203, 1'b1, "overrun at default limit");
        cmp(err, ERR_SCAN_OVERRUN, "overrun code");
        cmp(lout, 16'h0000, "outputs off on overrun");
        @(posedge clk);
        wd_limit <= 32'h0000_0064;
        wd_set   <= 1'b1;
        @(posedge clk);
        wd_set   <= 1'b0;
        wait_for(0, 60);
        cmp(err, ERR_NONE, "error cleared on run");
        finish_scan();
        wait_for(0, 40);
        cmp(s_max < 64, 1'b1, "stats cleared on run");
        ex(F_RST, 8'h00, 1'b0);
        n = 0;
        while (run_mode === 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        cmp(n >= 95 && n <= 103, 1'b1, "overrun at set limit");
        $display("watchdog test done");
    endtask

    initial begin
        {arst_n, run_req, bus_req, bus_local, bus_write, valid, ibit, wd_set} = '0;
        {local_in, remote_in, force_mask, force_val, bus_wdata, rtc} = '0;
        {loop_cfg, loop_due, flags, iaddr, wd_limit} = '0;
        bus_req   = 1'b1;
        bus_write = 1'b1;
        bus_wdata = 16'h0c3a;
        remote_in = 16'h00a5;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        t_program_mode();
        t_run_force();
        t_immediate();
        t_scan_time();
        t_watchdog();
        end_of_test();
    end
endmodule
`default_nettype wire
